// ==== rtl/buck_seq_defs.svh ====
// Purpose: Constants for the buck fault and hiccup sequencer
// Assumes: 125 MHz system clock
// Notes: Definitions only
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH

// ----------------------------------------
// Pin vector layout
// ----------------------------------------
`define PIN_W 16
`define PIN_EN_OFF 0
`define PIN_EN_ON 1
`define PIN_UVLO 2
`define PIN_DRV_UV 3
`define PIN_IN_UV 4
`define PIN_OT 5
`define PIN_OUT_UV 6
`define PIN_HS_ILIM 7
`define PIN_LS_ILIM 8
`define PIN_SW_CYC 9
`define PIN_SYNC 10
`define PIN_POWER_GOOD 11
`define PIN_SS_DONE 12
`define PIN_DT_LO 13
`define PIN_DT_HI 15

// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_AW 2
`define REG_DW 8
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_HICCUPS 2'h2
`define CTRL_RESET 8'h01
`define CTRL_RUN_BIT 0
`define HICCUPS_MAX 8'hFF

// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define CLK_HZ 125000000
`define HICCUP_TIME_MS 100
`define HICCUP_CYCLES (`HICCUP_TIME_MS * (`CLK_HZ / 1000))
`define HIC_W 24
`define OC_STEPS 4
`define OC_W 3

// ----------------------------------------
// Dead time in ns
// ----------------------------------------
`define DT_W 6
`define DT_DEFAULT_NS 6'h06
`define DT_STEP_NS 6'h06
`define DT_CODE_MAX 3'h7
`define DT_MAX_NS 6'h2A

`endif

// ==== rtl/buck_seq_pkg.sv ====
// Purpose: Types for the buck fault and hiccup sequencer
// Assumes: Nothing
// Notes: Used by scoped name only
package buck_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_STANDBY,
    ST_SOFTSTART,
    ST_RUN,
    ST_HICCUP,
    ST_FAULT
  } seq_state_e;
endpackage

// ==== rtl/pin_sync_if.sv ====
// Purpose: Carries raw pins to the filter and filtered levels back
// Assumes: One clock domain
// Notes: Width set by parameter
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface
`default_nettype wire

// ==== rtl/pin_filter.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to clk_sys
// Notes: Level changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_filter #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  pin_sync_if.filt pins
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;

  // ----------------------------------------
  // Stages and filter
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (clk_en) begin
      s1_r <= pins.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lvl_r <= '0;
    end else if (clk_en) begin
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  assign pins.level = lvl_r;
endmodule
`default_nettype wire

// ==== rtl/buck_fault_hiccup_sequencer.sv ====
// Purpose: Fault combining, overcurrent hiccup and start-up sequencing
// Assumes: Deglitched analogue flags, pins asynchronous to clk_sys
// Notes: Registers on a plain strobe port, read data one cycle later
//
// Behaviour
// - Internal fault is drive-supply UV, input UV or over-temperature
// - External fault is output UV or overcurrent latch
// - Enable below low threshold fully disables and discharges regulators
// - Turn-on only with enable and UVLO input both above threshold
// - UVLO hysteresis current turns on once UVLO input is above threshold and enable is above low threshold
// - Sync input ignored during start-up and without power good
// - Current-limit detects count up once per switching cycle
// - Cycle without detect counts down, saturating at zero
// - Counter overflow sets the overcurrent latch
// - Latch stops driver and oscillator, soft-start retried after hiccup delay
// - Default dead time, increased by the select pins
// - Select code 111 gives 42 ns, 011 gives 18 ns
// - Overcurrent beyond four cycles causes hiccup then restart
// - Hiccup repeats while overload persists, run resumes once clear
// - Over-temperature stops operation, full power-up once flag clears
`timescale 1ns/1ns
`default_nettype none
`include "buck_seq_defs.svh"
module buck_fault_hiccup_sequencer #(
  parameter int unsigned HICCUP_CYCLES = `HICCUP_CYCLES,
  parameter int HIC_W = `HIC_W,
  parameter int OC_STEPS = `OC_STEPS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic en_above_off,
  input wire logic en_above_on,
  input wire logic uvlo_above,
  input wire logic drive_supply_undervolt_flag,
  input wire logic input_undervolt_flag,
  input wire logic overtemp_flag,
  input wire logic output_undervolt_flag,
  input wire logic hs_ilim_det,
  input wire logic ls_ilim_det,
  input wire logic sw_cycle,
  input wire logic sync_in,
  input wire logic power_good,
  input wire logic ss_done,
  input wire logic deadtime_sel_0,
  input wire logic deadtime_sel_1,
  input wire logic deadtime_sel_2,
  input wire logic [`REG_AW-1:0] reg_addr,
  input wire logic [`REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`REG_DW-1:0] reg_rdata,
  output logic internal_fault,
  output logic external_fault,
  output logic overcurrent_latch_flag,
  output logic ldo_enable,
  output logic ldo_discharge,
  output logic uvlo_hyst_en,
  output logic driver_enable,
  output logic osc_enable,
  output logic ss_enable,
  output logic sync_out,
  output logic [`DT_W-1:0] deadtime_ns
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (HICCUP_CYCLES < 1 || HICCUP_CYCLES >= (64'd1 << HIC_W)) begin : g_chk_hic
    $error("HICCUP_CYCLES does not fit HIC_W");
  end
  if (OC_STEPS < 1 || OC_STEPS >= (1 << `OC_W)) begin : g_chk_oc
    $error("OC_STEPS does not fit the counter");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync_if #(.W(`PIN_W)) pins ();

  assign pins.raw = {deadtime_sel_2, deadtime_sel_1, deadtime_sel_0, ss_done, power_good,
                     sync_in, sw_cycle, ls_ilim_det, hs_ilim_det, output_undervolt_flag,
                     overtemp_flag, input_undervolt_flag, drive_supply_undervolt_flag,
                     uvlo_above, en_above_on, en_above_off};

  pin_filter #(.W(`PIN_W)) u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pins(pins)
  );

  logic en_off_q;
  logic en_on_q;
  logic uvlo_q;
  logic int_src_q;
  logic out_uv_q;
  logic ilim_q;
  logic sw_q;
  logic sync_q;
  logic pg_q;
  logic ss_done_q;
  logic [2:0] dt_q;

  assign en_off_q = pins.level[`PIN_EN_OFF];
  assign en_on_q = pins.level[`PIN_EN_ON];
  assign uvlo_q = pins.level[`PIN_UVLO];
  assign int_src_q = pins.level[`PIN_DRV_UV] | pins.level[`PIN_IN_UV] | pins.level[`PIN_OT];
  assign out_uv_q = pins.level[`PIN_OUT_UV];
  assign ilim_q = pins.level[`PIN_HS_ILIM] | pins.level[`PIN_LS_ILIM];
  assign sw_q = pins.level[`PIN_SW_CYC];
  assign sync_q = pins.level[`PIN_SYNC];
  assign pg_q = pins.level[`PIN_POWER_GOOD];
  assign ss_done_q = pins.level[`PIN_SS_DONE];
  assign dt_q = pins.level[`PIN_DT_HI:`PIN_DT_LO];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  buck_seq_pkg::seq_state_e state_r;
  buck_seq_pkg::seq_state_e state_nxt;
  logic [`REG_DW-1:0] ctrl_r;
  logic [`REG_DW-1:0] hiccups_r;
  logic [`REG_DW-1:0] status_w;
  logic [`OC_W-1:0] oc_cnt_r;
  logic oc_latch_r;

  assign status_w = {oc_latch_r, oc_cnt_r[1:0], internal_fault, external_fault,
                     3'(state_r)};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (clk_en && reg_wr && reg_addr == `REG_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      if (reg_rd) begin
        unique case (reg_addr)
          `REG_CTRL: reg_rdata <= ctrl_r;
          `REG_STATUS: reg_rdata <= status_w;
          `REG_HICCUPS: reg_rdata <= hiccups_r;
          default: reg_rdata <= '0;
        endcase
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ----------------------------------------
  // Fault combining
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      internal_fault <= 1'b0;
      external_fault <= 1'b0;
    end else if (clk_en) begin
      internal_fault <= int_src_q;
      external_fault <= out_uv_q | oc_latch_r;
    end
  end

  // ----------------------------------------
  // Overcurrent counter and latch
  // ----------------------------------------
  logic sw_prev_r;
  logic det_seen_r;
  logic cyc_edge;
  logic cyc_det;
  logic switching;
  logic oc_overflow;
  logic hic_done;

  assign cyc_edge = sw_q & ~sw_prev_r;
  assign cyc_det = det_seen_r | ilim_q;
  assign switching = (state_r == buck_seq_pkg::ST_SOFTSTART) || (state_r == buck_seq_pkg::ST_RUN);
  assign oc_overflow = switching && cyc_edge && cyc_det && oc_cnt_r == `OC_W'(OC_STEPS);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_prev_r <= 1'b0;
      det_seen_r <= 1'b0;
    end else if (clk_en) begin
      sw_prev_r <= sw_q;
      det_seen_r <= cyc_edge ? 1'b0 : cyc_det;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oc_cnt_r <= '0;
    end else if (clk_en) begin
      if (!switching) begin
        oc_cnt_r <= '0;
      end else if (cyc_edge && cyc_det) begin
        if (oc_cnt_r != `OC_W'(OC_STEPS)) begin
          oc_cnt_r <= oc_cnt_r + `OC_W'(1);
        end
      end else if (cyc_edge && oc_cnt_r != '0) begin
        oc_cnt_r <= oc_cnt_r - `OC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oc_latch_r <= 1'b0;
    end else if (clk_en) begin
      if (oc_overflow) begin
        oc_latch_r <= 1'b1;
      end else if (state_nxt == buck_seq_pkg::ST_SOFTSTART
                   && state_r != buck_seq_pkg::ST_SOFTSTART) begin
        oc_latch_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Hiccup timer
  // ----------------------------------------
  logic [HIC_W-1:0] hic_cnt_r;

  assign hic_done = hic_cnt_r == HIC_W'(HICCUP_CYCLES - 1);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hic_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == buck_seq_pkg::ST_HICCUP && !hic_done) begin
        hic_cnt_r <= hic_cnt_r + HIC_W'(1);
      end else begin
        hic_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hiccups_r <= '0;
    end else if (clk_en && oc_overflow && hiccups_r != `HICCUPS_MAX) begin
      hiccups_r <= hiccups_r + `REG_DW'(1);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!en_off_q) begin
      state_nxt = buck_seq_pkg::ST_OFF;
    end else begin
      unique case (state_r)
        buck_seq_pkg::ST_OFF: begin
          if (en_on_q) begin
            state_nxt = buck_seq_pkg::ST_STANDBY;
          end
        end
        buck_seq_pkg::ST_STANDBY: begin
          if (!en_on_q) begin
            state_nxt = buck_seq_pkg::ST_OFF;
          end else if (uvlo_q && !internal_fault && ctrl_r[`CTRL_RUN_BIT]) begin
            state_nxt = buck_seq_pkg::ST_SOFTSTART;
          end
        end
        buck_seq_pkg::ST_SOFTSTART, buck_seq_pkg::ST_RUN: begin
          if (internal_fault) begin
            state_nxt = buck_seq_pkg::ST_FAULT;
          end else if (oc_latch_r) begin
            state_nxt = buck_seq_pkg::ST_HICCUP;
          end else if (!uvlo_q || !ctrl_r[`CTRL_RUN_BIT]) begin
            state_nxt = buck_seq_pkg::ST_STANDBY;
          end else if (state_r == buck_seq_pkg::ST_SOFTSTART && ss_done_q) begin
            state_nxt = buck_seq_pkg::ST_RUN;
          end else if (state_r == buck_seq_pkg::ST_RUN && external_fault) begin
            state_nxt = buck_seq_pkg::ST_HICCUP;
          end
        end
        buck_seq_pkg::ST_HICCUP: begin
          if (internal_fault) begin
            state_nxt = buck_seq_pkg::ST_FAULT;
          end else if (hic_done) begin
            state_nxt = buck_seq_pkg::ST_SOFTSTART;
          end
        end
        buck_seq_pkg::ST_FAULT: begin
          if (!internal_fault) begin
            state_nxt = buck_seq_pkg::ST_STANDBY;
          end
        end
        default: state_nxt = buck_seq_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= buck_seq_pkg::ST_OFF;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Power-stage outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ldo_enable <= 1'b0;
      ldo_discharge <= 1'b1;
      driver_enable <= 1'b0;
      osc_enable <= 1'b0;
      ss_enable <= 1'b0;
      overcurrent_latch_flag <= 1'b0;
    end else if (clk_en) begin
      ldo_enable <= state_nxt != buck_seq_pkg::ST_OFF;
      ldo_discharge <= state_nxt == buck_seq_pkg::ST_OFF;
      driver_enable <= state_nxt == buck_seq_pkg::ST_SOFTSTART
                       || state_nxt == buck_seq_pkg::ST_RUN;
      osc_enable <= state_nxt == buck_seq_pkg::ST_SOFTSTART
                    || state_nxt == buck_seq_pkg::ST_RUN;
      ss_enable <= state_nxt == buck_seq_pkg::ST_SOFTSTART || state_nxt == buck_seq_pkg::ST_RUN;
      overcurrent_latch_flag <= oc_latch_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uvlo_hyst_en <= 1'b0;
    end else if (clk_en) begin
      uvlo_hyst_en <= uvlo_q && en_off_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_out <= 1'b0;
    end else if (clk_en) begin
      sync_out <= sync_q && pg_q && state_r == buck_seq_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      deadtime_ns <= `DT_DEFAULT_NS;
    end else if (clk_en) begin
      if (dt_q == 3'h0) begin
        deadtime_ns <= `DT_DEFAULT_NS;
      end else begin
        deadtime_ns <= `DT_W'(dt_q * `DT_STEP_NS);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_int_fault;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && int_src_q |=> internal_fault;
  endproperty
  a_int_fault: assert property (p_int_fault) else $error("internal fault missed");

  property p_ext_fault;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && oc_latch_r |=> external_fault && overcurrent_latch_flag;
  endproperty
  a_ext_fault: assert property (p_ext_fault) else $error("external fault missed");

  property p_disable;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !en_off_q |=> ldo_discharge && !ldo_enable && !driver_enable;
  endproperty
  a_disable: assert property (p_disable) else $error("not disabled");

  property p_turn_on;
    @(posedge clk_sys) disable iff (!rst_n)
    state_r == buck_seq_pkg::ST_STANDBY ##1 state_r == buck_seq_pkg::ST_SOFTSTART
      |-> $past(uvlo_q) && $past(en_on_q);
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("turn-on without uvlo");

  property p_hyst;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && uvlo_q && en_off_q |=> uvlo_hyst_en;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis source off");

  property p_sync_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !(pg_q && state_r == buck_seq_pkg::ST_RUN) |=> !sync_out;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync passed early");

  property p_overflow;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && switching && cyc_edge && cyc_det && oc_cnt_r == `OC_W'(OC_STEPS)
      |=> oc_latch_r ##1 !driver_enable;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not latched");

  property p_floor;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && cyc_edge && !cyc_det && oc_cnt_r == '0 |=> oc_cnt_r == '0;
  endproperty
  a_floor: assert property (p_floor) else $error("counter wrapped");

  property p_stop;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && oc_latch_r && state_nxt != buck_seq_pkg::ST_SOFTSTART
      |=> !driver_enable && !osc_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("driver on during latch");

  property p_dt_max;
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && dt_q == `DT_CODE_MAX |=> deadtime_ns == `DT_MAX_NS;
  endproperty
  a_dt_max: assert property (p_dt_max) else $error("dead time code 7 wrong");

  property p_restart_clear;
    @(posedge clk_sys) disable iff (!rst_n)
    state_r == buck_seq_pkg::ST_HICCUP ##1 state_r == buck_seq_pkg::ST_SOFTSTART
      |-> oc_cnt_r == '0 && !oc_latch_r;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("latch kept");

  c_hiccup: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == buck_seq_pkg::ST_HICCUP ##1 state_r == buck_seq_pkg::ST_SOFTSTART);
  c_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == buck_seq_pkg::ST_RUN);
  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == buck_seq_pkg::ST_FAULT ##1 state_r == buck_seq_pkg::ST_STANDBY);
  c_sync: cover property (@(posedge clk_sys) disable iff (!rst_n) sync_out);
endmodule
`default_nettype wire

// ==== verif/buck_far_side.sv ====
// Purpose: Far-side model: switching cycles, current-limit detects, sync
// Assumes: 16 clocks per switching cycle, oscillator halts when disabled
// Notes: Detects sit in the low phase, ahead of the cycle edge
`timescale 1ns/1ns
`default_nettype none
module buck_far_side (
  input wire logic clk_sys,
  input wire logic osc_enable,
  input wire logic sync_on,
  output logic sw_cycle,
  output logic hs_ilim_det,
  output logic ls_ilim_det,
  output logic sync_in
);
  logic [3:0] ph_r = 4'h0;
  logic [2:0] sy_r = 3'h0;
  logic hs_sel = 1'b0;
  logic ls_sel = 1'b0;
  int det_left = 0;
  logic det;
  // ----
  // Cycle source
  // ----
  always @(posedge clk_sys) begin
    ph_r <= osc_enable ? ph_r + 4'h1 : 4'h0;
    sy_r <= sy_r + 3'h1;
    if (ph_r == 4'h8 && det_left > 0)
      det_left <= det_left - 1;
  end
  assign sw_cycle = ph_r[3];
  assign det = det_left > 0 && ph_r inside {[4'h2:4'h5]};
  assign hs_ilim_det = hs_sel && det;
  assign ls_ilim_det = ls_sel && det;
  // Sync twice the cycle rate, ground when unused
  assign sync_in = sync_on && sy_r[2];
  // Detects in n consecutive cycles
  task automatic oc(input int n, input logic h, input logic l);
    int k;
    k = 0;
    // Start detects just after a cycle edge so every window is whole
    while (ph_r != 4'hA && k < 32) begin
      @(posedge clk_sys);
      k++;
    end
    k = 0;
    @(posedge clk_sys);
    hs_sel <= h;
    ls_sel <= l;
    det_left <= n;
    @(posedge clk_sys);
    while (det_left != 0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_buck_fault_hiccup_sequencer.sv ====
// Purpose: Self-checking bench for the buck fault and hiccup sequencer
// Assumes: Short hiccup count, far-side model for cycles and sync
// Notes: Pins reach the outputs about five clocks after a change
`timescale 1ns/1ns
`default_nettype none
`include "buck_seq_defs.svh"
`define CK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
`define PIN(s, v) begin @(posedge clk_sys); s <= v; wt(8); end
module tb_buck_fault_hiccup_sequencer;
  localparam int HC = 50;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic en_above_off = 1'b0, en_above_on = 1'b0, uvlo_above = 1'b0;
  logic drive_supply_undervolt_flag = 1'b0, input_undervolt_flag = 1'b0;
  logic overtemp_flag = 1'b0, output_undervolt_flag = 1'b0;
  logic power_good = 1'b1, ss_done = 1'b0, sync_on = 1'b0;
  logic deadtime_sel_0 = 1'b0, deadtime_sel_1 = 1'b0, deadtime_sel_2 = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
  logic [7:0] reg_rdata, rv;
  logic internal_fault, external_fault, overcurrent_latch_flag, ldo_enable;
  logic ldo_discharge, uvlo_hyst_en, driver_enable, osc_enable, ss_enable;
  logic sync_out, sw_cycle, hs_ilim_det, ls_ilim_det, sync_in;
  logic [`DT_W-1:0] deadtime_ns;
  int fail_count = 0, checked = 0, hits = 0;

  buck_fault_hiccup_sequencer #(.HICCUP_CYCLES(HC)) dut (
    .clk_sys, .rst_n, .clk_en, .en_above_off, .en_above_on, .uvlo_above,
    .drive_supply_undervolt_flag, .input_undervolt_flag, .overtemp_flag,
    .output_undervolt_flag, .hs_ilim_det, .ls_ilim_det, .sw_cycle, .sync_in,
    .power_good, .ss_done, .deadtime_sel_0, .deadtime_sel_1, .deadtime_sel_2,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_fault,
    .external_fault, .overcurrent_latch_flag, .ldo_enable, .ldo_discharge,
    .uvlo_hyst_en, .driver_enable, .osc_enable, .ss_enable, .sync_out,
    .deadtime_ns);
  buck_far_side far (.clk_sys, .osc_enable, .sync_on, .sw_cycle, .hs_ilim_det,
    .ls_ilim_det, .sync_in);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (sync_out === 1'b1) hits <= hits + 1;

  // ----
  // Access tasks
  // ----
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wt(8);
    `CK(ldo_discharge, 1'b1)
    `CK(deadtime_ns, `DT_DEFAULT_NS)
    rd(`REG_CTRL);
    `CK(rv, `CTRL_RESET)
    rd(2'h3);
    `CK(rv, 8'h00)
    wr(`REG_STATUS, 8'hFF);
    rd(`REG_STATUS);
    `CK(rv[2:0], 3'h0)
    `PIN({en_above_on, en_above_off}, 2'h3)
    `CK(ldo_enable, 1'b1)
    `CK(ss_enable, 1'b0)
    `CK(uvlo_hyst_en, 1'b0)
    `PIN(uvlo_above, 1'b1)
    `CK(uvlo_hyst_en, 1'b1)
    `CK(ss_enable, 1'b1)
    `CK(ldo_discharge, 1'b0)
    wr(`REG_CTRL, 8'h00);
    wt(3);
    rd(`REG_STATUS);
    `CK(rv[2:0], 3'h1)
    wr(`REG_CTRL, 8'h01);
    wt(3);
    rd(`REG_STATUS);
    `CK(rv[2:0], 3'h2)
    `PIN(sync_on, 1'b1)
    hits = 0;
    wt(40);
    `CK(hits, 0)
    `PIN(ss_done, 1'b1)
    rd(`REG_STATUS);
    `CK(rv[2:0], 3'h3)
    hits = 0;
    wt(40);
    `CK(hits > 0, 1'b1)
    `PIN(power_good, 1'b0)
    hits = 0;
    wt(40);
    `CK(hits, 0)
    `PIN(power_good, 1'b1)
    for (int c = 0; c < 8; c++) begin
      `PIN({deadtime_sel_2, deadtime_sel_1, deadtime_sel_0}, 3'(c))
      `CK(deadtime_ns, (c == 0) ? `DT_DEFAULT_NS : 6'(6 * c))
    end
    for (int i = 0; i < 3; i++) begin
      `PIN({overtemp_flag, input_undervolt_flag, drive_supply_undervolt_flag}, 3'(1 << i))
      `CK(internal_fault, 1'b1)
      `CK(driver_enable, 1'b0)
      rd(`REG_STATUS);
      `CK(rv[4], 1'b1)
      `CK(rv[2:0], 3'h5)
      `PIN({overtemp_flag, input_undervolt_flag, drive_supply_undervolt_flag}, 3'h0)
      wt(8);
      `CK(internal_fault, 1'b0)
      `CK(driver_enable, 1'b1)
    end
    far.oc(3, 1'b1, 1'b0);
    wt(96);
    far.oc(4, 1'b0, 1'b1);
    `CK(overcurrent_latch_flag, 1'b0)
    wt(96);
    for (int k = 1; k < 3; k++) begin
      far.oc(5, k == 1, k == 2);
      `CK(overcurrent_latch_flag, 1'b1)
      `CK(external_fault, 1'b1)
      `CK(driver_enable, 1'b0)
      `CK(osc_enable, 1'b0)
      rd(`REG_STATUS);
      `CK(rv[2:0], 3'h4)
      wt(HC - 20);
      `CK(driver_enable, 1'b0)
      wt(30);
      `CK(overcurrent_latch_flag, 1'b0)
      `CK(driver_enable, 1'b1)
      rd(`REG_HICCUPS);
      `CK(rv, 8'(k))
    end
    `PIN(output_undervolt_flag, 1'b1)
    `CK(external_fault, 1'b1)
    `CK(overcurrent_latch_flag, 1'b0)
    `PIN(output_undervolt_flag, 1'b0)
    wt(HC + 10);
    `CK(external_fault, 1'b0)
    `PIN(clk_en, 1'b0)
    `PIN({en_above_on, en_above_off}, 2'h0)
    `CK(ldo_enable, 1'b1)
    `PIN(clk_en, 1'b1)
    `CK(ldo_enable, 1'b0)
    `CK(ldo_discharge, 1'b1)
    `CK(driver_enable, 1'b0)
    close_out();
  end

  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
